//--- common/omc_pkg.sv
// omc_pkg: shared constants and types of the optical module management block
package omc_pkg;

	// ----------------------------------------
	// sizes and timing
	// ----------------------------------------
	localparam int NQ           = 5;
	localparam int VW           = 16;
	localparam int NFL          = 4;
	localparam int CLK_HZ       = 25_000_000;
	localparam int POR_HOLD_MS  = 140;
	// least time: 25 MHz divides evenly, so no rounding is needed
	localparam int POR_HOLD_CYC = (CLK_HZ / 1000) * POR_HOLD_MS;

	// ----------------------------------------
	// two-wire serial addressing
	// ----------------------------------------
	localparam logic [6:0] ID_DEV_ADDR   = 7'h50;
	localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
	localparam logic [3:0] BIT_LAST      = 4'h7;
	localparam logic [3:0] BIT_ACK       = 4'h8;

	// ----------------------------------------
	// identification memory content
	// ----------------------------------------
	// values arbitrary, loaded per product at build time
	localparam logic [7:0] ID_TYPE_OFS = 8'h00;
	localparam logic [7:0] ID_TYPE_VAL = 8'h03;
	localparam logic [7:0] ID_FILL     = 8'h00;

	// ----------------------------------------
	// diagnostic map layout
	// ----------------------------------------
	localparam logic [7:0] THR_END    = 8'h28;
	localparam logic [7:0] VAL_BASE   = 8'h60;
	localparam logic [7:0] VAL_END    = 8'h6A;
	localparam logic [7:0] STAT_OFS   = 8'h6E;
	localparam logic [7:0] ALM_HI_OFS = 8'h70;
	localparam logic [7:0] ALM_LO_OFS = 8'h71;
	localparam logic [7:0] WRN_HI_OFS = 8'h74;
	localparam logic [7:0] WRN_LO_OFS = 8'h75;
	localparam int ST_TXOFF   = 7;
	localparam int ST_FAULT   = 2;
	localparam int ST_NOLIGHT = 1;
	localparam int ST_POR     = 0;
	localparam int FL_AH      = 3;
	localparam int FL_AL      = 2;
	localparam int FL_WH      = 1;
	localparam int FL_WL      = 0;

	// ----------------------------------------
	// factory thresholds and trim, index 4 down to 0
	// ----------------------------------------
	typedef logic [NQ-1:0][VW-1:0] omc_qv_t;
	localparam omc_qv_t THR_ALM_HI = {16'hF000, 16'hF000, 16'hF000, 16'hF000, 16'hF000};
	localparam omc_qv_t THR_ALM_LO = {16'h0400, 16'h0400, 16'h0400, 16'h0400, 16'h0400};
	localparam omc_qv_t THR_WRN_HI = {16'hE000, 16'hE000, 16'hE000, 16'hE000, 16'hE000};
	localparam omc_qv_t THR_WRN_LO = {16'h0800, 16'h0800, 16'h0800, 16'h0800, 16'h0800};
	localparam omc_qv_t CAL_OFS    = {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

	typedef enum {S_DEVADDR, S_OFFSET, S_WDATA, S_READ, S_IDLE} omc_tw_e;

endpackage

//--- common/omc_lim_if.sv
// omc_lim_if: one monitored value, its thresholds and its flags
interface omc_lim_if;
	import omc_pkg::*;
	logic [VW-1:0]  value;
	logic [VW-1:0]  alm_hi;
	logic [VW-1:0]  alm_lo;
	logic [VW-1:0]  wrn_hi;
	logic [VW-1:0]  wrn_lo;
	logic [NFL-1:0] flags;
	modport chk (input value, alm_hi, alm_lo, wrn_hi, wrn_lo, output flags);
	modport src (output value, alm_hi, alm_lo, wrn_hi, wrn_lo, input flags);
endinterface

//--- hdl/omc_sync.sv
// omc_sync: two-stage synchroniser for pin levels
module omc_sync
	import omc_pkg::*;
#(
	parameter int           W  = 1,
	parameter logic [W-1:0] RV = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] st1_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st1_reg <= RV;
			q       <= RV;
		end else begin
			st1_reg <= d;
			q       <= st1_reg;
		end
	end
endmodule

//--- hdl/omc_limit.sv
// omc_limit: alarm and warning compare for one monitored value
module omc_limit
	import omc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	omc_lim_if.chk    lim
);
	logic [NFL-1:0] flags_reg;
	logic [NFL-1:0] flags_next;

	always_comb begin
		flags_next        = '0;
		flags_next[FL_AH] = lim.value > lim.alm_hi;
		flags_next[FL_AL] = lim.value < lim.alm_lo;
		flags_next[FL_WH] = lim.value > lim.wrn_hi;
		flags_next[FL_WL] = lim.value < lim.wrn_lo;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign lim.flags = flags_reg;
endmodule

//--- hdl/omc_top.sv
// omc_top: laser control, supervisory reset and two-wire serial maps
module omc_top
	import omc_pkg::*;
#(
	parameter int POR_CYC = POR_HOLD_CYC
) (
	input  wire logic             CLK,
	input  wire logic             RST,
	input  wire logic             ID_SERIAL_CLOCK,
	input  wire logic             ID_SERIAL_DATA_I,
	output logic                  ID_SERIAL_DATA_O,
	output logic                  ID_SERIAL_DATA_OE,
	input  wire logic             TRANSMIT_OFF_IN,
	input  wire logic             SUPPLY_LOW,
	input  wire logic             LASER_FAULT_DET,
	input  wire logic             RX_DARK,
	input  wire logic [NQ*VW-1:0] MON_RAW,
	input  wire logic             MON_VALID,
	output logic                  LASER_EN,
	output logic                  TX_FAULT,
	output logic                  NO_LIGHT_FLAG,
	output logic                  MODULE_PRESENT,
	output logic                  INT_RESET
);
	localparam int PCW = $clog2(POR_CYC + 1);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic txoff_s;
	logic supply_low_s;
	logic fault_s;
	logic dark_s;
	logic scl_s;
	logic sda_s;

	// open input reads as disabled from reset
	omc_sync #(.W(1), .RV(1'b1)) u_sync_txoff (
		.clk (CLK),
		.rst (RST),
		.d   (TRANSMIT_OFF_IN),
		.q   (txoff_s)
	);

	omc_sync #(.W(1), .RV(1'b1)) u_sync_supply (
		.clk (CLK),
		.rst (RST),
		.d   (SUPPLY_LOW),
		.q   (supply_low_s)
	);

	omc_sync #(.W(2), .RV(2'h0)) u_sync_stat (
		.clk (CLK),
		.rst (RST),
		.d   ({LASER_FAULT_DET, RX_DARK}),
		.q   ({fault_s, dark_s})
	);

	omc_sync #(.W(2), .RV(2'h3)) u_sync_bus (
		.clk (CLK),
		.rst (RST),
		.d   ({ID_SERIAL_CLOCK, ID_SERIAL_DATA_I}),
		.q   ({scl_s, sda_s})
	);

	// ----------------------------------------
	// supervisory reset and laser control
	// ----------------------------------------
	logic           por_reg;
	logic           por_next;
	logic [PCW-1:0] por_cnt_reg;
	logic [PCW-1:0] por_cnt_next;
	logic           fault_reg;
	logic           fault_next;
	logic           laser_reg;
	logic           laser_next;
	logic           nolight_reg;
	logic           nolight_next;
	logic           present_reg;

	always_comb begin
		por_next     = por_reg;
		por_cnt_next = por_cnt_reg;
		if (supply_low_s) begin
			por_next     = 1'b1;
			por_cnt_next = '0;
		end else if (por_reg) begin
			if (por_cnt_reg == PCW'(POR_CYC - 1)) begin
				por_next = 1'b0;
			end else begin
				por_cnt_next = por_cnt_reg + PCW'(1);
			end
		end
		// fault latches, set wins over clear
		fault_next = fault_s | (fault_reg & ~txoff_s & ~por_reg);
		laser_next = ~por_next & ~txoff_s & ~fault_next;
		nolight_next = dark_s;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			por_reg     <= 1'b1;
			por_cnt_reg <= '0;
			fault_reg   <= 1'b0;
			laser_reg   <= 1'b0;
			nolight_reg <= 1'b1;
			present_reg <= 1'b0;
		end else begin
			por_reg     <= por_next;
			por_cnt_reg <= por_cnt_next;
			fault_reg   <= fault_next;
			laser_reg   <= laser_next;
			nolight_reg <= nolight_next;
			present_reg <= 1'b0;
		end
	end

	assign TX_FAULT       = fault_reg;
	assign LASER_EN       = laser_reg;
	assign NO_LIGHT_FLAG  = nolight_reg;
	assign MODULE_PRESENT = present_reg;
	assign INT_RESET      = por_reg;

	// ----------------------------------------
	// frame detection and diagnostic capture
	// ----------------------------------------
	logic                  sda_q_reg;
	logic                  scl_q_reg;
	logic                  busy_reg;
	logic                  busy_next;
	logic                  clr_reg;
	logic                  clr_next;
	omc_qv_t               val_reg;
	omc_qv_t               val_next;
	logic [7:0]            stat_reg;
	logic [7:0]            stat_next;
	logic                  start_det;
	logic                  stop_det;

	// values are frozen for the whole frame so the serial side reads
	// stable words without a per-byte handshake
	always_comb begin
		// clock high on two samples: with a fast link clock a data change set up
		// just before the rise would otherwise look like a start or stop
		start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
		stop_det  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
		busy_next = start_det | (busy_reg & ~stop_det);
		clr_next  = start_det | stop_det;
		val_next  = val_reg;
		stat_next = stat_reg;
		if (!busy_reg) begin
			if (MON_VALID) begin
				for (int i = 0; i < NQ; i++) begin
					val_next[i] = MON_RAW[i*VW +: VW] + CAL_OFS[i];
				end
			end
			stat_next             = '0;
			stat_next[ST_TXOFF]   = txoff_s;
			stat_next[ST_FAULT]   = fault_reg;
			stat_next[ST_NOLIGHT] = nolight_reg;
			stat_next[ST_POR]     = por_reg;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sda_q_reg <= 1'b1;
			scl_q_reg <= 1'b1;
			busy_reg  <= 1'b0;
			clr_reg   <= 1'b0;
			val_reg   <= '0;
			stat_reg  <= '0;
		end else begin
			sda_q_reg <= sda_s;
			scl_q_reg <= scl_s;
			busy_reg  <= busy_next;
			clr_reg   <= clr_next;
			val_reg   <= val_next;
			stat_reg  <= stat_next;
		end
	end

	// ----------------------------------------
	// threshold checkers
	// ----------------------------------------
	logic [NQ-1:0] fl_ah;
	logic [NQ-1:0] fl_al;
	logic [NQ-1:0] fl_wh;
	logic [NQ-1:0] fl_wl;

	for (genvar g = 0; g < NQ; g++) begin : g_lim
		omc_lim_if lim_if ();
		assign lim_if.value  = val_reg[g];
		assign lim_if.alm_hi = THR_ALM_HI[g];
		assign lim_if.alm_lo = THR_ALM_LO[g];
		assign lim_if.wrn_hi = THR_WRN_HI[g];
		assign lim_if.wrn_lo = THR_WRN_LO[g];
		omc_limit u_lim (
			.clk (CLK),
			.rst (RST),
			.lim (lim_if)
		);
		// split into alarm and warning bytes
		assign fl_ah[g] = lim_if.flags[FL_AH];
		assign fl_al[g] = lim_if.flags[FL_AL];
		assign fl_wh[g] = lim_if.flags[FL_WH];
		assign fl_wl[g] = lim_if.flags[FL_WL];
	end

	// ----------------------------------------
	// serial side: map read mux
	// ----------------------------------------
	logic [7:0]    ofs_reg;
	logic          sel_reg;
	logic [7:0]    tx_byte;
	logic [7:0]    rel;
	logic [VW-1:0] word;

	always_comb begin
		tx_byte = ID_FILL;
		rel     = ofs_reg - VAL_BASE;
		word    = '0;
		if (!sel_reg) begin
			if (ofs_reg == ID_TYPE_OFS) begin
				tx_byte = ID_TYPE_VAL;
			end
		end else if (ofs_reg < THR_END) begin
			unique case (ofs_reg[2:1])
				2'h0: word = THR_ALM_HI[ofs_reg[5:3]];
				2'h1: word = THR_ALM_LO[ofs_reg[5:3]];
				2'h2: word = THR_WRN_HI[ofs_reg[5:3]];
				2'h3: word = THR_WRN_LO[ofs_reg[5:3]];
			endcase
			tx_byte = ofs_reg[0] ? word[7:0] : word[15:8];
		end else if (ofs_reg >= VAL_BASE && ofs_reg < VAL_END) begin
			word    = val_reg[rel[3:1]];
			tx_byte = rel[0] ? word[7:0] : word[15:8];
		end else begin
			unique case (ofs_reg)
				STAT_OFS:   tx_byte = stat_reg;
				ALM_HI_OFS: tx_byte = 8'(fl_ah);
				ALM_LO_OFS: tx_byte = 8'(fl_al);
				WRN_HI_OFS: tx_byte = 8'(fl_wh);
				WRN_LO_OFS: tx_byte = 8'(fl_wl);
				default:    tx_byte = ID_FILL;
			endcase
		end
	end

	// ----------------------------------------
	// serial side: byte engine on the link clock
	// ----------------------------------------
	omc_tw_e    st_reg;
	omc_tw_e    st_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic [7:0] sh_reg;
	logic [7:0] sh_next;
	logic       ack_reg;
	logic       ack_next;
	logic [7:0] ofs_next;
	logic       sel_next;
	logic [7:0] rx_byte;
	logic       tw_rst;
	logic       oe_reg;
	logic       oe_next;
	logic       sdo_reg;

	// start or stop restarts the byte engine; offset survives a repeated start
	assign tw_rst = RST | clr_reg;

	always_comb begin
		st_next  = st_reg;
		cnt_next = cnt_reg;
		sh_next  = sh_reg;
		ack_next = ack_reg;
		ofs_next = ofs_reg;
		sel_next = sel_reg;
		rx_byte  = {sh_reg[6:0], ID_SERIAL_DATA_I};
		if (st_reg != S_IDLE) begin
			if (cnt_reg != BIT_ACK) begin
				sh_next  = rx_byte;
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == BIT_LAST) begin
					unique case (st_reg)
						S_DEVADDR: begin
							if (rx_byte[7:1] == ID_DEV_ADDR || rx_byte[7:1] == DIAG_DEV_ADDR) begin
								ack_next = 1'b1;
								sel_next = rx_byte[7:1] == DIAG_DEV_ADDR;
								st_next  = rx_byte[0] ? S_READ : S_OFFSET;
							end else begin
								st_next = S_IDLE;
							end
						end
						S_OFFSET: begin
							ofs_next = rx_byte;
							ack_next = 1'b1;
							st_next  = S_WDATA;
						end
						S_WDATA: begin
							// maps are read only; written data is acked and dropped
							ack_next = 1'b1;
							ofs_next = ofs_reg + 8'h01;
						end
						S_READ, S_IDLE: begin
						end
					endcase
				end
			end else begin
				cnt_next = '0;
				ack_next = 1'b0;
				if (st_reg == S_READ && !ack_reg) begin
					if (ID_SERIAL_DATA_I) begin
						st_next = S_IDLE;
					end else begin
						ofs_next = ofs_reg + 8'h01;
					end
				end
			end
		end
	end

	always_ff @(posedge ID_SERIAL_CLOCK or posedge tw_rst) begin
		if (tw_rst) begin
			st_reg  <= S_DEVADDR;
			cnt_reg <= '0;
			sh_reg  <= '0;
			ack_reg <= 1'b0;
		end else begin
			st_reg  <= st_next;
			cnt_reg <= cnt_next;
			sh_reg  <= sh_next;
			ack_reg <= ack_next;
		end
	end

	always_ff @(posedge ID_SERIAL_CLOCK or posedge RST) begin
		if (RST) begin
			ofs_reg <= '0;
			sel_reg <= 1'b0;
		end else begin
			ofs_reg <= ofs_next;
			sel_reg <= sel_next;
		end
	end

	// data line driven low only, changes while the clock is low
	always_comb begin
		oe_next = 1'b0;
		if (cnt_reg == BIT_ACK) begin
			oe_next = ack_reg;
		end else if (st_reg == S_READ) begin
			oe_next = ~tx_byte[3'(BIT_LAST[2:0] - cnt_reg[2:0])];
		end
	end

	always_ff @(negedge ID_SERIAL_CLOCK or posedge tw_rst) begin
		if (tw_rst) begin
			oe_reg  <= 1'b0;
			sdo_reg <= 1'b0;
		end else begin
			oe_reg  <= oe_next;
			sdo_reg <= 1'b0;
		end
	end

	assign ID_SERIAL_DATA_OE = oe_reg;
	assign ID_SERIAL_DATA_O  = sdo_reg;
endmodule

//--- sim/omc_top_assertions.sv
// omc_top_assertions: port checks of laser control, supervisory reset, no-light flag and presence output
module omc_top_assertions
	import omc_pkg::*;
#(
	parameter int POR_CYC = POR_HOLD_CYC
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic TRANSMIT_OFF_IN,
	input wire logic SUPPLY_LOW,
	input wire logic LASER_FAULT_DET,
	input wire logic RX_DARK,
	input wire logic LASER_EN,
	input wire logic TX_FAULT,
	input wire logic NO_LIGHT_FLAG,
	input wire logic MODULE_PRESENT,
	input wire logic INT_RESET
);
	timeunit 1ns;
	timeprecision 100ps;
	int good_cnt_reg;
	int good_cnt_next;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);
	// cycles the supply has stayed good; two sync stages make it a few more than the hold
	always_comb begin
		good_cnt_next = SUPPLY_LOW ? 0 : good_cnt_reg + 1;
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			good_cnt_reg <= 0;
		end else begin
			good_cnt_reg <= good_cnt_next;
		end
	end
	sequence s_dark;
		RX_DARK [*3];
	endsequence
	sequence s_lit;
		!RX_DARK [*3];
	endsequence
	sequence s_off;
		TRANSMIT_OFF_IN [*3];
	endsequence
	sequence s_fault;
		LASER_FAULT_DET [*3];
	endsequence
	a_supply_reset: assert property (
		$rose(SUPPLY_LOW) |-> ##3 INT_RESET) else $error("reset late");
	a_hold_time: assert property (
		$fell(INT_RESET) |-> good_cnt_reg >= POR_CYC) else $error("hold short");
	a_laser_hold: assert property (
		INT_RESET |-> !LASER_EN) else $error("laser on in reset");
	a_txoff_kill: assert property (
		s_off |=> !LASER_EN) else $error("laser on while off");
	a_laser_start: assert property (
		$rose(LASER_EN) |-> $past(TRANSMIT_OFF_IN, 3) == 1'b0 && $past(LASER_FAULT_DET, 3) == 1'b0)
		else $error("bad laser start");
	a_fault_shut: assert property (
		s_fault |=> TX_FAULT && !LASER_EN) else $error("fault not shut");
	a_fault_clear: assert property (
		$fell(TX_FAULT) |-> $past(LASER_FAULT_DET, 3) == 1'b0
		&& ($past(TRANSMIT_OFF_IN, 3) || $past(INT_RESET) || INT_RESET)) else $error("bad clear");
	a_dark_flag: assert property (
		s_dark |=> NO_LIGHT_FLAG) else $error("dark not flagged");
	a_lit_flag: assert property (
		s_lit |=> !NO_LIGHT_FLAG) else $error("light flagged");
	a_present_gnd: assert property (
		!MODULE_PRESENT) else $error("presence not low");
endmodule

bind omc_top omc_top_assertions #(.POR_CYC(POR_CYC)) omc_top_assertions_inst (
	.CLK(CLK), .RST(RST), .TRANSMIT_OFF_IN(TRANSMIT_OFF_IN), .SUPPLY_LOW(SUPPLY_LOW),
	.LASER_FAULT_DET(LASER_FAULT_DET), .RX_DARK(RX_DARK), .LASER_EN(LASER_EN),
	.TX_FAULT(TX_FAULT), .NO_LIGHT_FLAG(NO_LIGHT_FLAG), .MODULE_PRESENT(MODULE_PRESENT),
	.INT_RESET(INT_RESET)
);

//--- sim/omc_host.sv
// omc_host: behavioural two-wire host master on the serial id lines
module omc_host (
	output logic      scl,
	output logic      sda_h,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	logic r;
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	task automatic bit_x(input logic b, output logic q);
		#20 sda_h = b;
		#20 scl = 1'b1;
		#40 q = sda;
		scl = 1'b0;
	endtask
	// long holds: start and stop are seen through the system clock synchronisers
	task automatic start();
		#20 sda_h = 1'b1;
		#400 scl = 1'b1;
		#400 sda_h = 1'b0;
		#400 scl = 1'b0;
	endtask
	task automatic stop();
		#20 sda_h = 1'b0;
		#400 scl = 1'b1;
		#400 sda_h = 1'b1;
		#400;
	endtask
	task automatic wb(input logic [7:0] v, output logic a);
		for (int i = 7; i >= 0; i--) bit_x(v[i], r);
		bit_x(1'b1, a);
	endtask
	task automatic rb(input logic last, output logic [7:0] v);
		for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
		bit_x(last, r);
	endtask
endmodule

//--- sim/omc_top_tb.sv
// omc_top_tb: self-checking bench for the optical module management block
module omc_top_tb
	import omc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int POR = 20;
	logic             clk = 1'b0;
	logic             rst = 1'b0;
	logic             txoff = 1'b0;
	logic             sup = 1'b0;
	logic             flt = 1'b0;
	logic             dark = 1'b0;
	logic             mv = 1'b0;
	logic [NQ*VW-1:0] raw = '0;
	logic             scl, sda_h, sda, sdo, oe, len, txf, nol, pres, ires, a1;
	logic [15:0]      v;
	int               n;
	int               mismatches = 0;
	int               comparisons = 0;
	logic [7:0]       fo [4] = '{ALM_HI_OFS, ALM_LO_OFS, WRN_HI_OFS, WRN_LO_OFS};
	logic [7:0]       fe [4] = '{8'h02, 8'h04, 8'h0A, 8'h14};
	// pull-up on the data line, device pulls low while enabled
	assign sda = sda_h & ~oe;
	always #20 clk = ~clk;
	omc_top #(.POR_CYC(POR)) omc_top_inst (
		.CLK(clk), .RST(rst), .ID_SERIAL_CLOCK(scl), .ID_SERIAL_DATA_I(sda),
		.ID_SERIAL_DATA_O(sdo), .ID_SERIAL_DATA_OE(oe), .TRANSMIT_OFF_IN(txoff),
		.SUPPLY_LOW(sup), .LASER_FAULT_DET(flt), .RX_DARK(dark), .MON_RAW(raw),
		.MON_VALID(mv), .LASER_EN(len), .TX_FAULT(txf), .NO_LIGHT_FLAG(nol),
		.MODULE_PRESENT(pres), .INT_RESET(ires)
	);
	omc_host omc_host_inst (.scl(scl), .sda_h(sda_h), .sda(sda));
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#5;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic fall(output int k);
		k = 0;
		while (ires !== 1'b0 && k < 1000) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic rd(input logic [6:0] d, input logic [7:0] o, input int k,
		output logic [15:0] r);
		logic a;
		logic [7:0] b;
		r = '0;
		omc_host_inst.start();
		omc_host_inst.wb({d, 1'b0}, a);
		chk(16'(a), 16'h0000);
		omc_host_inst.wb(o, a);
		omc_host_inst.start();
		omc_host_inst.wb({d, 1'b1}, a);
		for (int i = 0; i < k; i++) begin
			omc_host_inst.rb(i == k - 1, b);
			r = {r[7:0], b};
		end
		omc_host_inst.stop();
	endtask
	task automatic results();
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#500_000;
		mismatches++;
		results();
	end
	initial begin
		// raised after time zero so every asynchronous reset sees an edge
		#1;
		rst = 1'b1;
		cyc(19);
		chk({10'h000, ires, len, txf, nol, pres, oe}, 16'h0024);
		cyc(1);
		rst = 1'b0;
		fall(n);
		chk(16'(n >= POR), 16'h0001);
		chk({14'h0000, ires, len}, 16'h0001);
		sup = 1'b1;
		cyc(3);
		chk({14'h0000, ires, len}, 16'h0002);
		sup = 1'b0;
		fall(n);
		chk(16'(n), 16'(POR + 2));
		txoff = 1'b1;
		cyc(3);
		chk(16'(len), 16'h0000);
		txoff = 1'b0;
		cyc(3);
		chk(16'(len), 16'h0001);
		flt = 1'b1;
		cyc(3);
		chk({14'h0000, txf, len}, 16'h0002);
		flt = 1'b0;
		cyc(4);
		rd(DIAG_DEV_ADDR, STAT_OFS, 1, v);
		chk(v, 16'h0004);
		chk({14'h0000, txf, len}, 16'h0002);
		txoff = 1'b1;
		cyc(3);
		chk(16'(txf), 16'h0000);
		txoff = 1'b0;
		cyc(3);
		chk(16'(len), 16'h0001);
		dark = 1'b1;
		cyc(3);
		chk(16'(nol), 16'h0001);
		rd(DIAG_DEV_ADDR, STAT_OFS, 1, v);
		chk(v, 16'h0002);
		dark = 1'b0;
		cyc(3);
		chk(16'(nol), 16'h0000);
		raw = {16'h0600, 16'hE800, 16'h0200, 16'hF800, 16'h1234};
		mv = 1'b1;
		cyc(1);
		mv = 1'b0;
		cyc(2);
		for (int q = 0; q < NQ; q++) begin
			rd(DIAG_DEV_ADDR, VAL_BASE + 8'(2 * q), 2, v);
			chk(v, raw[16 * q +: 16]);
		end
		for (int i = 0; i < 4; i++) begin
			rd(DIAG_DEV_ADDR, fo[i], 1, v);
			chk(v, {8'h00, fe[i]});
		end
		rd(DIAG_DEV_ADDR, 8'h00, 2, v);
		chk(v, THR_ALM_HI[0]);
		rd(ID_DEV_ADDR, ID_TYPE_OFS, 2, v);
		chk(v, {ID_TYPE_VAL, ID_FILL});
		omc_host_inst.start();
		omc_host_inst.wb(8'hA4, a1);
		omc_host_inst.stop();
		chk(16'(a1), 16'h0001);
		chk(16'(sdo), 16'h0000);
		results();
	end
endmodule
